/* hdl/pwq_top.sv */
// Pulse width trigger qualifier: measures pulses and issues triggers.
//
// Behaviour
// (RQ1) Four compare modes, each with either polarity.
// (RQ2) Equal mode fires on matching trailing edge.
// (RQ3) Not-equal: short pulse fires at trailing edge.
// (RQ4) Not-equal: long pulse fires at limit, early.
// (RQ5) Less-than fires on trailing edge below width.
// (RQ6) Greater-than fires once width is exceeded.
// (RQ7) Width settable 33 ns to 10 s.
// (RQ8) Width step is 16.5 ns or 0.1%.
// (RQ9) Equal band 16.5 ns, else about 5%.
// (RQ10) Not-equal band by width: 16.5/33 ns, 5%.
// (RQ11) Counter starts at leading edge, ticks per clock.
// (RQ12) One-cycle trigger, at most one per pulse.
`timescale 1ns/1ps
module pwq_top
    import pwq_pkg::*;
#(
    parameter int MAX_WIDTH_CYC = WIDTH_MAX_CYC,  // Longest width setting.
    parameter int CW            = CNT_W           // Counter width.
) (
    input  wire logic          CLOCK,        // 20 MHz sample clock.
    input  wire logic          SYS_RST,      // Synchronous reset, active high.
    input  wire logic          COMP_IN,      // Comparator output.
    input  wire logic [1:0]    MODE,         // Compare mode.
    input  wire logic          POL_NEG,      // High measures negative pulses.
    input  wire logic [CW-1:0] WIDTH,        // Width setting in clock ticks.
    output logic               TRIG_OUT,     // One-cycle trigger pulse.
    output logic               PULSE_ACTIVE, // Pulse in progress.
    output logic [CW-1:0]      WIDTH_MEAS    // Width of the last ended pulse.
);

    ////////////////////////////////////////////////////////////////////////////
    // Refuse a longest width below the shortest, or one the counter cannot hold.
    if (MAX_WIDTH_CYC < WIDTH_MIN_CYC) begin : g_max
        $error("Longest width below shortest width.");
    end
    if (longint'(MAX_WIDTH_CYC) + longint'(MAX_WIDTH_CYC / 16) >= (64'd1 << CW)) begin : g_cw
        $error("Counter too narrow for the longest width.");
    end

    localparam logic [CW-1:0] W_MIN   = CW'(WIDTH_MIN_CYC);
    localparam logic [CW-1:0] W_MAX   = CW'(MAX_WIDTH_CYC);
    localparam logic [CW-1:0] STEP    = CW'(STEP_CYC);
    localparam logic [CW-1:0] NE_HI   = CW'(NE_HI_CYC);
    localparam logic [CW-1:0] EQ_SM   = CW'(EQ_SMALL_CYC);
    localparam logic [CW-1:0] NE_SM   = CW'(NE_SMALL_CYC);
    localparam logic [CW+3:0] P_MUL   = (CW+4)'(PCT_MUL);
    localparam logic [CW+3:0] P_RND   = (CW+4)'((1 << PCT_SHIFT) - 1);

    pwq_mode_t     mode;
    pwq_state_t    state_reg;
    pwq_state_t    state_next;
    logic [CW-1:0] w_reg;
    logic [CW-1:0] tol_reg;
    logic [CW-1:0] ne_hi_reg;
    logic [CW-1:0] cnt;
    logic          act;
    logic          lead;
    logic          trail;

    assign mode = pwq_mode_t'(MODE);

    ////////////////////////////////////////////////////////////////////////////
    // Polarity and edges of the comparator output.
    pwq_edge u_edge (
        .clk     (CLOCK),
        .rst     (SYS_RST),
        .comp_in (COMP_IN),
        .pol_neg (POL_NEG),   // see RQ1
        .act_reg (act),
        .lead    (lead),
        .trail   (trail)
    );

    // The count restarts on each leading edge and runs while active.
    pwq_count #(.W(CW)) u_count (
        .clk       (CLOCK),
        .rst       (SYS_RST),
        .start     (lead),            // see RQ11
        .run       (act),             // see RQ11
        .count_reg (cnt)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Width setting clamped to the legal span; one tick of 50 ns is
    // already coarser than 16.5 ns, so no finer step can be asked for.
    wire [CW-1:0] w_clamp = (WIDTH < W_MIN) ? W_MIN :
                            (WIDTH > W_MAX) ? W_MAX : WIDTH;  // see RQ7
    wire [CW+3:0] w_prod  = (CW+4)'(w_clamp) * P_MUL;
    wire [CW-1:0] w_pct   = CW'((w_prod + P_RND) >> PCT_SHIFT);

    // Equal band: one step when short, else the rounded-up percentage.
    wire [CW-1:0] tol_calc = (w_clamp <= EQ_SM) ? STEP : w_pct;  // see RQ9

    // Not-equal upper band: extra margin between the two short limits.
    wire [CW-1:0] ne_hi_calc = (w_clamp <= NE_SM) ? STEP :
                               (w_clamp <= EQ_SM) ? NE_HI : w_pct;  // see RQ10

    // Registering the setting costs one tick of latency on a change
    // but keeps the multiply off the trigger path.
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            w_reg     <= W_MIN;
            tol_reg   <= STEP;
            ne_hi_reg <= STEP;
        end else begin
            w_reg     <= w_clamp;     // see RQ8
            tol_reg   <= tol_calc;
            ne_hi_reg <= ne_hi_calc;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Band edges. The lower edge is never below zero: the band is
    // never larger than the width for any legal setting.
    wire [CW-1:0] eq_lo = w_reg - tol_reg;
    wire [CW-1:0] eq_hi = w_reg + tol_reg;
    wire [CW-1:0] ne_lo = w_reg - tol_reg;
    wire [CW-1:0] ne_up = w_reg + ne_hi_reg;

    // Decisions at the trailing edge, on the finished count.
    wire in_eq   = (cnt >= eq_lo) && (cnt <= eq_hi);         // see RQ9
    wire t_equal = (mode == MODE_EQUAL) && in_eq;            // see RQ2
    wire t_short = (mode == MODE_NOTEQ) && (cnt < ne_lo);    // see RQ3
    wire t_less  = (mode == MODE_LESS) && (cnt < w_reg);     // see RQ5
    wire fire_tr = trail && (state_reg == ST_MEAS) && (t_equal || t_short || t_less);

    // Decisions while the pulse is still active: cnt counts the earlier
    // samples, so cnt at a limit means the pulse has passed it. At or past,
    // so that a width lowered during a long pulse still fires at once.
    wire on_pulse = act && !lead && (state_reg == ST_MEAS);
    wire t_tout   = (mode == MODE_GREATER) && (cnt >= w_reg);  // see RQ6
    wire t_long   = (mode == MODE_NOTEQ) && (cnt >= ne_up);    // see RQ4
    wire fire_to  = on_pulse && (t_tout || t_long);

    wire fire = fire_tr || fire_to;

    ////////////////////////////////////////////////////////////////////////////
    // Pulse state: once a pulse has fired it is parked until it ends,
    // which is what keeps it to a single trigger.
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (lead) begin
                    state_next = ST_MEAS;
                end
            end
            ST_MEAS: begin
                if (trail) begin
                    state_next = ST_IDLE;
                end else if (fire_to) begin
                    state_next = ST_FIRED;   // see RQ12
                end
            end
            ST_FIRED: begin
                if (trail) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // Outputs are all registered.
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            state_reg  <= ST_IDLE;
            TRIG_OUT   <= 1'b0;
            WIDTH_MEAS <= CW'(CNT_RST);
        end else begin
            state_reg <= state_next;
            TRIG_OUT  <= fire;             // see RQ12
            if (trail) begin
                WIDTH_MEAS <= cnt;
            end
        end
    end

    assign PULSE_ACTIVE = act;

    ////////////////////////////////////////////////////////////////////////////
    // Checks on the qualifier's own behaviour.
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (SYS_RST);

    sequence s_eq_match;
        trail && state_reg == ST_MEAS && mode == MODE_EQUAL
            && cnt >= w_reg - tol_reg && cnt <= w_reg + tol_reg;
    endsequence

    sequence s_ne_long;
        act && !lead && state_reg == ST_MEAS && mode == MODE_NOTEQ
            && cnt == w_reg + ne_hi_reg;
    endsequence

    sequence s_gt_long;
        act && !lead && state_reg == ST_MEAS && mode == MODE_GREATER && cnt == w_reg;
    endsequence

    property p_pol;
        !$past(SYS_RST) |-> PULSE_ACTIVE == $past(COMP_IN ^ POL_NEG);
    endproperty
    a_pol: assert property (p_pol) else $error("Polarity not applied.");  // see RQ1

    property p_eq;
        s_eq_match |=> TRIG_OUT;
    endproperty
    a_eq: assert property (p_eq) else $error("Equal match missed.");  // see RQ2

    property p_ne_short;
        trail && state_reg == ST_MEAS && mode == MODE_NOTEQ && cnt < w_reg - tol_reg
            |=> TRIG_OUT;
    endproperty
    a_ne_short: assert property (p_ne_short) else $error("Short pulse missed.");  // see RQ3

    property p_ne_long;
        s_ne_long ##1 act |-> TRIG_OUT && state_reg == ST_FIRED;
    endproperty
    a_ne_long: assert property (p_ne_long) else $error("Long pulse missed.");  // see RQ4

    property p_less;
        trail && mode == MODE_LESS && cnt >= w_reg |=> !TRIG_OUT;
    endproperty
    a_less: assert property (p_less) else $error("Less-than fired wide.");  // see RQ5

    property p_gt;
        s_gt_long |=> TRIG_OUT ##1 !TRIG_OUT;
    endproperty
    a_gt: assert property (p_gt) else $error("Time-out trigger wrong.");  // see RQ6

    property p_range;
        w_reg >= W_MIN && w_reg <= W_MAX;
    endproperty
    a_range: assert property (p_range) else $error("Width out of span.");  // see RQ7

    property p_eq_out;
        trail && mode == MODE_EQUAL && (cnt > w_reg + tol_reg || cnt < w_reg - tol_reg)
            |=> !TRIG_OUT;
    endproperty
    a_eq_out: assert property (p_eq_out) else $error("Equal fired outside band.");  // see RQ9

    property p_ne_band;
        trail && mode == MODE_NOTEQ && cnt >= w_reg - tol_reg && cnt <= w_reg + ne_hi_reg
            |=> !TRIG_OUT;
    endproperty
    a_ne_band: assert property (p_ne_band) else $error("Not-equal fired in band.");  // see RQ10

    property p_count;
        lead ##1 act |-> cnt == 1 ##1 (!act || cnt == 2);
    endproperty
    a_count: assert property (p_count) else $error("Counter start wrong.");  // see RQ11

    property p_once;
        TRIG_OUT |-> state_reg != ST_MEAS;
    endproperty
    a_once: assert property (p_once) else $error("Second trigger possible.");  // see RQ12

    property p_pulse;
        TRIG_OUT |=> !TRIG_OUT;
    endproperty
    a_pulse: assert property (p_pulse) else $error("Trigger wider than one cycle.");  // see RQ12

    // Further checks on the trigger decisions made and withheld, the bands, the measured width and the parked state.
    sequence s_trail_meas;
        trail && state_reg == ST_MEAS;
    endsequence

    property p_less_hit;
        s_trail_meas ##0 (mode == MODE_LESS && cnt < w_reg) |=> TRIG_OUT;
    endproperty
    a_less_hit: assert property (p_less_hit) else $error("Less-than trigger missed.");  // see RQ5

    property p_gt_trail;
        trail && mode == MODE_GREATER |=> !TRIG_OUT;
    endproperty
    a_gt_trail: assert property (p_gt_trail) else $error("Greater fired at trail.");  // see RQ6

    property p_tol_pct;
        w_reg > EQ_SM |-> tol_reg * 20 >= w_reg;
    endproperty
    a_tol_pct: assert property (p_tol_pct) else $error("Equal band below 5 percent.");  // see RQ9

    property p_ne_hi;
        w_reg > NE_SM && w_reg <= EQ_SM |-> ne_hi_reg == NE_HI;
    endproperty
    a_ne_hi: assert property (p_ne_hi) else $error("Not-equal upper band wrong.");  // see RQ10

    property p_meas;
        trail |=> WIDTH_MEAS == $past(cnt);
    endproperty
    a_meas: assert property (p_meas) else $error("Measured width not captured.");  // see RQ11

    property p_from_meas;
        TRIG_OUT |-> $past(state_reg) == ST_MEAS;
    endproperty
    a_from_meas: assert property (p_from_meas) else $error("Trigger without a pulse.");  // see RQ12

    property p_fired;
        state_reg == ST_FIRED |=> !TRIG_OUT;
    endproperty
    a_fired: assert property (p_fired) else $error("Parked pulse fired again.");  // see RQ12

endmodule

/* hdl/pwq_pkg.sv */
// Shared constants and types of the pulse width trigger qualifier.
package pwq_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Clock and time figures, times in picoseconds as printed, the longest width in seconds.
    localparam int CLK_HZ        = 20_000_000;
    localparam int CLK_PERIOD_PS = 50_000;
    localparam int WIDTH_MIN_PS  = 33_000;
    localparam int WIDTH_MAX_S   = 10;
    localparam int STEP_PS       = 16_500;
    localparam int EQ_SMALL_PS   = 330_000;
    localparam int NE_SMALL_PS   = 165_000;
    localparam int NE_HI_PS      = 33_000;

    ////////////////////////////////////////////////////////////////////////////
    // Derived cycle counts: least times round up, limits round down.
    localparam int WIDTH_MIN_CYC = (WIDTH_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int WIDTH_MAX_CYC = WIDTH_MAX_S * CLK_HZ;
    localparam int STEP_CYC      = (STEP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int NE_HI_CYC     = (NE_HI_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int EQ_SMALL_CYC  = EQ_SMALL_PS / CLK_PERIOD_PS;
    localparam int NE_SMALL_CYC  = NE_SMALL_PS / CLK_PERIOD_PS;

    // Percentage band: width * 13 / 256 is 5.08 percent of the width.
    localparam int PCT_MUL       = 13;
    localparam int PCT_SHIFT     = 8;

    // Counter width and reset value.
    localparam int CNT_W         = 28;
    localparam int CNT_RST       = 0;

    typedef enum logic [1:0] {MODE_LESS, MODE_GREATER, MODE_EQUAL, MODE_NOTEQ} pwq_mode_t;
    typedef enum logic [1:0] {ST_IDLE, ST_MEAS, ST_FIRED} pwq_state_t;

endpackage

/* hdl/pwq_edge.sv */
// Polarity selection and edge detection of the comparator output.
`timescale 1ns/1ps
module pwq_edge
    import pwq_pkg::*;
(
    input  wire logic clk,      // Sample clock.
    input  wire logic rst,      // Synchronous reset, active high.
    input  wire logic comp_in,  // Digitised comparator output.
    input  wire logic pol_neg,  // High selects negative pulses.
    output logic      act_reg,  // Pulse active in the chosen polarity.
    output wire logic lead,     // First sample of a pulse.
    output wire logic trail     // First sample after a pulse.
);

    logic prev_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Inverting for negative pulses lets one measuring path serve both.
    always_ff @(posedge clk) begin
        if (rst) begin
            act_reg  <= 1'b0;
            prev_reg <= 1'b0;
        end else begin
            act_reg  <= comp_in ^ pol_neg;
            prev_reg <= act_reg;
        end
    end

    // Edges are taken from registered samples only.
    assign lead  = act_reg & ~prev_reg;
    assign trail = ~act_reg & prev_reg;

endmodule

/* hdl/pwq_count.sv */
// Saturating width counter of the pulse width trigger qualifier.
`timescale 1ns/1ps
module pwq_count #(
    parameter int W = 28        // Counter width.
) (
    input  wire logic         clk,       // Sample clock.
    input  wire logic         rst,       // Synchronous reset, active high.
    input  wire logic         start,     // Leading edge seen.
    input  wire logic         run,       // Pulse still active.
    output logic [W-1:0]      count_reg  // Active samples so far.
);

    logic [W-1:0] count_next;
    wire          sat = &count_reg;

    // A one-bit counter could not tell a fresh start from saturation.
    if (W < 2) begin : g_w
        $error("Counter width too small.");
    end

    // Saturation keeps a very long pulse from wrapping into a short one.
    always_comb begin
        count_next = count_reg;
        if (start) begin
            count_next = W'(1);
        end else if (run && !sat) begin
            count_next = count_reg + W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_next;
        end
    end

endmodule

/* dv/pwq_src.sv */
// Behavioural comparator model that drives pulses into the qualifier.
`timescale 1ns/1ps
module pwq_src (
    input  wire logic clk,      // Sample clock.
    input  wire logic pol_neg,  // High makes pulses low-going.
    output wire logic comp_out, // Comparator level toward the qualifier.
    output int        cyc       // Rising edges seen since time zero.
);
    localparam time DLY = 2ns;
    logic drv = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // The idle level follows the polarity, so a polarity change is never an edge.
    assign comp_out = drv ^ pol_neg;
    // Edge counter shared with the bench for timing expectations.
    always @(posedge clk) cyc <= cyc + 1;

    // One pulse of n samples, then g+1 idle samples before the next may start.
    task automatic drive(input int n, input int g);
        @(posedge clk);
        #DLY drv = 1'b1;
        repeat (n) @(posedge clk);
        #DLY drv = 1'b0;
        repeat (g) @(posedge clk);
        #DLY;
    endtask
endmodule

/* dv/pwq_top_tb.sv */
// Self-checking bench of the pulse width trigger qualifier.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin n_mismatch++; \
    $display("ERROR %s expected %0d seen %0d", nm, ex, got); end end
module pwq_top_tb
    import pwq_pkg::*;
;
    localparam int  MAXW = 1000;
    localparam time DLY  = 2ns;
    typedef struct {int cyc; int meas;} pwq_note_t;
    logic             clock   = 1'b0;
    logic             sys_rst = 1'b1;
    logic [1:0]       mode    = 2'h0;
    logic             pol_neg = 1'b0;
    logic [CNT_W-1:0] width   = 28'h1;
    logic             act_exp = 1'b0;
    wire logic             comp;
    wire logic             trig;
    wire logic             act;
    wire logic [CNT_W-1:0] meas;
    int        cyc;
    int        n_mismatch      = 0;
    int        samples_checked = 0;
    int        wl[8]           = '{0, 1, 3, 4, 6, 7, 20, 60};
    pwq_note_t q[$];

    ////////////////////////////////////////////////////////////////////////////
    // Small maximum keeps the clamp test short.
    pwq_top #(.MAX_WIDTH_CYC(MAXW), .CW(CNT_W)) i_dut (
        .CLOCK(clock), .SYS_RST(sys_rst), .COMP_IN(comp), .MODE(mode), .POL_NEG(pol_neg),
        .WIDTH(width), .TRIG_OUT(trig), .PULSE_ACTIVE(act), .WIDTH_MEAS(meas));
    pwq_src i_src (.clk(clock), .pol_neg(pol_neg), .comp_out(comp), .cyc(cyc));

    always #25 clock = ~clock;

    // Expected trigger cycle for one pulse of n samples launched after edge c0.
    function automatic pwq_note_t expect_of(int m, int wi, int n, int c0);
        int        w;
        int        tol;
        int        hi;
        pwq_note_t r;
        w = (wi < WIDTH_MIN_CYC) ? WIDTH_MIN_CYC : ((wi > MAXW) ? MAXW : wi);
        tol = (w * PCT_MUL + (1 << PCT_SHIFT) - 1) >> PCT_SHIFT;
        tol = (w <= EQ_SMALL_CYC) ? STEP_CYC : tol;
        hi = (w <= NE_SMALL_CYC) ? STEP_CYC : ((w <= EQ_SMALL_CYC) ? NE_HI_CYC : tol);
        r.cyc = -1;
        r.meas = n;
        case (m)
            MODE_LESS: if (n < w) r.cyc = c0 + n + 2;
            MODE_GREATER: if (n > w) begin
                r.cyc = c0 + w + 2;
                r.meas = -1;
            end
            MODE_EQUAL: if (n >= w - tol && n <= w + tol) r.cyc = c0 + n + 2;
            default: if (n < w - tol) r.cyc = c0 + n + 2;
            else if (n > w + hi) begin
                r.cyc = c0 + w + hi + 2;
                r.meas = -1;
            end
        endcase
        return r;
    endfunction

    // The driver notes the expectation before the pulse starts, since timeouts
    // fire while it is still active.
    task automatic pulse(input int n, input int g);
        pwq_note_t r;
        r = expect_of(mode, width, n, cyc + 1);
        if (r.cyc >= 0) q.push_back(r);
        i_src.drive(n, g);
    endtask

    // Settings change only while idle, because the mode is used live.
    task automatic setup(input int m, input int p, input int w);
        repeat (3) @(posedge clock);
        #DLY mode = 2'(m);
        pol_neg = p[0];
        width = CNT_W'(w);
        repeat (3) @(posedge clock);
        #DLY;
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Monitor: each trigger takes the oldest note; a late note is a missed trigger.
    always @(posedge clock) act_exp <= sys_rst ? 1'b0 : comp ^ pol_neg;
    always @(negedge clock) begin
        if (!sys_rst) `CHK("pulse_active", act_exp, act)
        if (!sys_rst) `CHK("trig_known", 1'b0, $isunknown(trig))
        if (q.size() > 0 && q[0].cyc < cyc) begin
            `CHK("trig_missing", q[0].cyc, -1)
            void'(q.pop_front());
        end
        if (trig === 1'b1) begin
            if (q.size() == 0) `CHK("trig_extra", 0, 1)
            else begin
                `CHK("trig_cycle", q[0].cyc, cyc)
                if (q[0].meas >= 0) `CHK("width_meas", CNT_W'(q[0].meas), meas)
                void'(q.pop_front());
            end
        end
    end

    // Main sequence: boundary sweep of every mode and polarity, clamp, then random.
    initial begin
        int lo;
        void'($urandom(32'h5672));
        repeat (8) @(posedge clock);
        #DLY sys_rst = 1'b0;
        foreach (wl[i]) for (int m = 0; m < 4; m++) for (int p = 0; p < 2; p++) begin
            setup(m, p, wl[i]);
            lo = (wl[i] - wl[i] / 8 - 3 < 1) ? 1 : wl[i] - wl[i] / 8 - 3;
            for (int n = lo; n <= wl[i] + wl[i] / 8 + 4; n++) pulse(n, n % 3);
        end
        setup(MODE_GREATER, 0, 32'h1000);
        pulse(MAXW + 10, 2);
        for (int k = 0; k < 200; k++) begin
            if (k % 10 == 0) setup($urandom % 4, $urandom % 2, 1 + $urandom % 40);
            pulse(1 + $urandom % 90, $urandom % 3);
        end
        repeat (10) @(posedge clock);
        `CHK("notes_left", 0, q.size())
        final_report();
    end

    // Watchdog well beyond the expected run length.
    initial begin
        repeat (60000) @(posedge clock);
        n_mismatch++;
        final_report();
    end
endmodule
